// ### pll_pd_model.sv
// Purpose: Phase detector stand-in that issues reference ticks with a commanded phase error.
// Assumes: One tick every four clock cycles while run is high.
// Notes: Between ticks the error lines flip to the inverse of their previous value every cycle.
`timescale 1ns/1ns
module pll_pd_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] err,
  output logic pd_tick,
  output logic [7:0] phase_err_ns
);
  logic [1:0] div_ff;

  // Divides the clock into reference cycles; the error is only valid with its tick.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 2'h0;
      pd_tick <= 1'b0;
      phase_err_ns <= 8'hFF;
    end else begin
      div_ff <= run ? div_ff + 2'h1 : 2'h0;
      pd_tick <= run && (div_ff == 2'h3);
      phase_err_ns <= (run && (div_ff == 2'h3)) ? err : ~phase_err_ns;
    end
  end
endmodule

// ### pll_supervisor.sv
// Purpose: Lock detector, fractional compensation gate and fast-acquire timeout for a synthesizer.
// Assumes: pd_tick is a one-cycle pulse per phase detector cycle; phase_err_ns is its phase error.
// Notes: AXI4-Lite slave for configuration; one level interrupt on lock gain and loss.
`timescale 1ns/1ns
`include "pll_supervisor_cfg.svh"

// Summary of operation
// [R01] Host keeps compensation off in integer mode.
// [R02] Host enables compensation in fractional mode.
// [R03] Compensation circuitry follows its enable bit.
// [R04] Lock after five cycles inside narrow window.
// [R05] When locked, drop lock beyond wide window.
// [R06] Power down forces lock low.
// [R07] Timeout bounds fast acquisition duration.
// [R08] Disengage restores steady pump and frequency.
// [R09] Host never sets fast gain below steady.
// [R10] Host keeps gain and frequency product above one.
// [R11] Mode field zero integer, one fractional.
// [R12] Steady gain field used when fast acquisition off.
// [R13] Run counter clears on miss or power down.
// [R14] Timeout loads on frequency write, counts, disengages.
module pll_supervisor #(
  parameter int TOC_W = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pd_tick,
  input wire logic [7:0] phase_err_ns,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic lock_detect,
  output pll_supervisor_pkg::analog_t analog_ctrl,
  output logic irq
);
  pll_supervisor_pkg::ctrl_t ctrl_ff, nxt_ctrl;
  logic [TOC_W-1:0] toc_ff, nxt_toc;
  logic [TOC_W-1:0] tcnt_ff, nxt_tcnt;
  logic fast_ff, nxt_fast;
  logic [1:0] ist_ff, nxt_ist;
  logic [1:0] imask_ff, nxt_imask;
  logic aw_ff, nxt_aw, w_ff, nxt_w;
  logic [11:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic [31:0] rd_ff, nxt_rd;
  pll_supervisor_pkg::lock_state_t ld_ff, nxt_ld;
  logic [2:0] run_ff, nxt_run;
  pll_supervisor_pkg::analog_t an_ff, nxt_an;
  logic irq_ff, nxt_irq;
  logic wr_go, freq_wr, in_narrow, in_wide, lock_rise, lock_fall;

  // Write handshake: address and data are taken in either order, response after both.
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    wr_go = aw_ff && w_ff && !bv_ff;
    if (wr_go) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = 2'h0;
      if (awa_ff != `OFS_CTRL && awa_ff != `OFS_TIMEOUT && awa_ff != `OFS_FREQ &&
          awa_ff != `OFS_STATUS && awa_ff != `OFS_IRQ_STAT && awa_ff != `OFS_IRQ_MASK) begin
        nxt_br = 2'h2;
      end
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
  end

  // Register writes, fast-acquire timeout and interrupt status.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_toc = toc_ff;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    freq_wr = 1'b0;
    if (wr_go) begin
      if (awa_ff == `OFS_CTRL) begin
        nxt_ctrl = pll_supervisor_pkg::ctrl_t'(wd_ff[9:0]);
      end else if (awa_ff == `OFS_TIMEOUT) begin
        nxt_toc = wd_ff[TOC_W-1:0];
      end else if (awa_ff == `OFS_FREQ) begin
        freq_wr = 1'b1;
      end else if (awa_ff == `OFS_IRQ_STAT) begin
        nxt_ist = ist_ff & ~wd_ff[1:0];
      end else if (awa_ff == `OFS_IRQ_MASK) begin
        nxt_imask = wd_ff[1:0];
      end
    end
    nxt_ist = nxt_ist | {lock_fall, lock_rise}; // Set wins over clear.
    nxt_tcnt = tcnt_ff;
    nxt_fast = fast_ff;
    if (freq_wr && toc_ff >= TOC_W'(`TOC_FIRST_TIMED)) begin
      nxt_tcnt = toc_ff; // see [R14]
      nxt_fast = 1'b1;
    end else if (fast_ff && pd_tick) begin
      if (tcnt_ff <= TOC_W'(1)) begin
        nxt_tcnt = '0;
        nxt_fast = 1'b0; // see [R07] see [R14]
      end else begin
        nxt_tcnt = tcnt_ff - TOC_W'(1);
      end
    end
    if (ctrl_ff.power_down || toc_ff < TOC_W'(`TOC_FIRST_TIMED)) begin
      nxt_fast = 1'b0;
    end
  end

  // Lock filter: narrow window to acquire, wide window to hold.
  assign in_narrow = phase_err_ns < 8'(`NARROW_WIN_NS);
  assign in_wide = phase_err_ns <= 8'(`WIDE_WIN_NS);
  always_comb begin
    nxt_ld = ld_ff;
    nxt_run = run_ff;
    if (ctrl_ff.power_down) begin
      nxt_ld = pll_supervisor_pkg::LD_SEEK; // see [R06]
      nxt_run = 3'h0; // see [R13]
    end else if (pd_tick) begin
      case (ld_ff)
        pll_supervisor_pkg::LD_SEEK: begin
          if (!in_narrow) begin
            nxt_run = 3'h0; // see [R13]
          end else if (run_ff + 3'h1 >= `LOCK_RUN) begin
            nxt_run = 3'h0;
            nxt_ld = pll_supervisor_pkg::LD_LOCKED; // see [R04]
          end else begin
            nxt_run = run_ff + 3'h1;
          end
        end
        default: begin
          if (!in_wide) begin
            nxt_ld = pll_supervisor_pkg::LD_SEEK; // see [R05]
          end
        end
      endcase
    end
    lock_rise = (nxt_ld == pll_supervisor_pkg::LD_LOCKED) && (ld_ff == pll_supervisor_pkg::LD_SEEK);
    lock_fall = (nxt_ld == pll_supervisor_pkg::LD_SEEK) && (ld_ff == pll_supervisor_pkg::LD_LOCKED);
  end

  // Analog control outputs, interrupt and read data.
  always_comb begin
    nxt_an.frac_comp_on = ctrl_ff.fractional_comp_enable; // see [R03]
    nxt_an.fast_engaged = fast_ff || toc_ff == `TOC_MANUAL;
    nxt_an.pump_gain = ctrl_ff.hi_band_pump_gain; // see [R08] see [R12]
    nxt_an.slip_reduction = 2'h0; // see [R08]
    if (toc_ff == `TOC_MANUAL) begin
      nxt_an.pump_gain = 2'h3;
    end else if (fast_ff) begin
      nxt_an.pump_gain = ctrl_ff.fast_pump_gain;
      if (ctrl_ff.hi_band_op_mode == pll_supervisor_pkg::MODE_FRACTIONAL) begin
        nxt_an.slip_reduction = ctrl_ff.slip_reduction; // see [R11]
      end
    end
    nxt_irq = |(ist_ff & imask_ff);
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = 2'h0;
      if (s_axi_araddr == `OFS_CTRL) begin
        nxt_rd = {22'h0, ctrl_ff};
      end else if (s_axi_araddr == `OFS_TIMEOUT) begin
        nxt_rd = 32'(toc_ff);
      end else if (s_axi_araddr == `OFS_FREQ) begin
        nxt_rd = 32'h0;
      end else if (s_axi_araddr == `OFS_STATUS) begin
        nxt_rd = {2'h0, 2'(tcnt_ff >> (TOC_W - 2)), 12'(tcnt_ff), 14'h0, fast_ff, lock_detect};
      end else if (s_axi_araddr == `OFS_IRQ_STAT) begin
        nxt_rd = {30'h0, ist_ff};
      end else if (s_axi_araddr == `OFS_IRQ_MASK) begin
        nxt_rd = {30'h0, imask_ff};
      end else begin
        nxt_rd = 32'h0;
        nxt_rr = 2'h2;
      end
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // Register stage for all state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= pll_supervisor_pkg::ctrl_t'(`CTRL_RESET);
      toc_ff <= '0;
      tcnt_ff <= '0;
      fast_ff <= 1'b0;
      ist_ff <= 2'h0;
      imask_ff <= 2'h0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      rv_ff <= 1'b0;
      rr_ff <= 2'h0;
      rd_ff <= 32'h0000_0000;
      ld_ff <= pll_supervisor_pkg::LD_SEEK;
      run_ff <= 3'h0;
      an_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      toc_ff <= nxt_toc;
      tcnt_ff <= nxt_tcnt;
      fast_ff <= nxt_fast;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rr_ff <= nxt_rr;
      rd_ff <= nxt_rd;
      ld_ff <= nxt_ld;
      run_ff <= nxt_run;
      an_ff <= nxt_an;
      irq_ff <= nxt_irq;
    end
  end

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign lock_detect = ld_ff == pll_supervisor_pkg::LD_LOCKED;
  assign analog_ctrl = an_ff;
  assign irq = irq_ff;

  // Lock needs a run of five narrow-window ticks; the fifth hit arrives with four already counted.
  sequence s_fifth_hit;
    pd_tick && in_narrow && !ctrl_ff.power_down && !lock_detect && run_ff == 3'h4;
  endsequence
  property p_lock_needs_run;
    @(posedge aclk) disable iff (!aresetn)
      $rose(lock_detect) |-> $past(in_narrow) && $past(pd_tick) && $past(run_ff) == 3'h4;
  endproperty
  a_lock_needs_run: assert property (p_lock_needs_run) else $error("Lock rose without narrow hit."); // see [R04]
  property p_lock_after_run;
    @(posedge aclk) disable iff (!aresetn)
      s_fifth_hit |=> lock_detect;
  endproperty
  a_lock_after_run: assert property (p_lock_after_run) else $error("Lock missing after five hits."); // see [R04]
  property p_wide_drop;
    @(posedge aclk) disable iff (!aresetn)
      lock_detect && pd_tick && !in_wide |=> !lock_detect;
  endproperty
  a_wide_drop: assert property (p_wide_drop) else $error("Lock held past wide window."); // see [R05]
  property p_pd_low;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_ff.power_down |=> !lock_detect && run_ff == 3'h0;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("Lock not low in power down."); // see [R06]
  property p_run_clear;
    @(posedge aclk) disable iff (!aresetn)
      pd_tick && !in_narrow && !lock_detect |=> run_ff == 3'h0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("Run counter kept after a miss."); // see [R13]
  property p_comp_follow;
    @(posedge aclk) disable iff (!aresetn)
      ##1 analog_ctrl.frac_comp_on == $past(ctrl_ff.fractional_comp_enable);
  endproperty
  a_comp_follow: assert property (p_comp_follow) else $error("Compensation enable mismatch."); // see [R03]
  property p_steady_gain;
    @(posedge aclk) disable iff (!aresetn)
      !fast_ff && toc_ff != `TOC_MANUAL |=> analog_ctrl.pump_gain == $past(ctrl_ff.hi_band_pump_gain);
  endproperty
  a_steady_gain: assert property (p_steady_gain) else $error("Steady gain not applied."); // see [R12]
  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
      $fell(fast_ff) && toc_ff != `TOC_MANUAL |=> analog_ctrl.slip_reduction == 2'h0 && !analog_ctrl.fast_engaged;
  endproperty
  a_restore: assert property (p_restore) else $error("Steady settings not restored."); // see [R08]
  property p_timeout_load;
    @(posedge aclk) disable iff (!aresetn)
      freq_wr && toc_ff >= TOC_W'(`TOC_FIRST_TIMED) && !ctrl_ff.power_down |=> fast_ff && tcnt_ff == $past(toc_ff);
  endproperty
  a_timeout_load: assert property (p_timeout_load) else $error("Timeout not loaded."); // see [R14]
  property p_timeout_end;
    @(posedge aclk) disable iff (!aresetn)
      fast_ff && pd_tick && tcnt_ff == TOC_W'(1) && !freq_wr |=> !fast_ff;
  endproperty
  a_timeout_end: assert property (p_timeout_end) else $error("Fast acquisition outlived timeout."); // see [R07]
  property p_mode_csr;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_ff.hi_band_op_mode != pll_supervisor_pkg::MODE_FRACTIONAL |=> analog_ctrl.slip_reduction == 2'h0;
  endproperty
  a_mode_csr: assert property (p_mode_csr) else $error("Slip reduction outside fractional mode."); // see [R11]
endmodule

// ### pll_supervisor_cfg.svh
// Purpose: Offsets, reset values, window widths and timing counts of the synthesizer supervisor.
// Assumes: 32-bit AXI4-Lite register words at byte addresses.
// Notes: Definitions only.
`ifndef PLL_SUPERVISOR_CFG_SVH
`define PLL_SUPERVISOR_CFG_SVH
`define OFS_CTRL 12'h000
`define OFS_TIMEOUT 12'h004
`define OFS_FREQ 12'h008
`define OFS_STATUS 12'h00C
`define OFS_IRQ_STAT 12'h010
`define OFS_IRQ_MASK 12'h014
`define CTRL_RESET 32'h0000_0000
`define TIMEOUT_RESET 14'h0000
`define LOCK_RUN 3'h5
`define NARROW_WIN_NS 15
`define WIDE_WIN_NS 30
`define CLK_PERIOD_NS 4
`define NARROW_WIN_CYC ((`NARROW_WIN_NS) / (`CLK_PERIOD_NS))
`define WIDE_WIN_CYC ((`WIDE_WIN_NS) / (`CLK_PERIOD_NS))
`define TOC_MANUAL 14'h0002
`define TOC_FIRST_TIMED 14'h0004
`endif

// ### pll_supervisor_pkg.sv
// Purpose: Types shared by the synthesizer supervisor.
// Assumes: Nothing beyond the cfg header.
// Notes: Holds types only.
package pll_supervisor_pkg;
  typedef enum logic [1:0] {MODE_INTEGER, MODE_FRACTIONAL, MODE_RSVD2, MODE_RSVD3} op_mode_t;
  typedef struct packed {
    logic [1:0] slip_reduction;
    logic [1:0] fast_pump_gain;
    logic [1:0] hi_band_pump_gain;
    logic [1:0] hi_band_op_mode;
    logic fractional_comp_enable;
    logic power_down;
  } ctrl_t;
  typedef struct packed {
    logic [1:0] pump_gain;
    logic [1:0] slip_reduction;
    logic frac_comp_on;
    logic fast_engaged;
  } analog_t;
  typedef enum logic {LD_SEEK, LD_LOCKED} lock_state_t;
endpackage

// ### tb.sv
// Purpose: Self-checking bench for the synthesizer supervisor.
// Assumes: Bus answers are compared by a monitor against a queue of expected values.
// Notes: Reference ticks come from pll_pd_model.
`timescale 1ns/1ns
`include "pll_supervisor_cfg.svh"
module tb;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic run = 1'b0;
  logic [7:0] perr = 8'h14;
  logic pd_tick;
  logic [7:0] phase_err_ns;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lock_detect, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pll_supervisor_pkg::analog_t ac;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  exp_t q[$];
  exp_t e_cur;

  // Free-running bench clock.
  always #2 aclk = ~aclk;

  pll_supervisor u_pll_supervisor (.aclk(aclk), .aresetn(aresetn), .pd_tick(pd_tick),
    .phase_err_ns(phase_err_ns), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lock_detect(lock_detect), .analog_ctrl(ac), .irq(irq));
  pll_pd_model u_pll_pd_model (.aclk(aclk), .aresetn(aresetn), .run(run), .err(perr),
    .pd_tick(pd_tick), .phase_err_ns(phase_err_ns));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Takes the oldest expectation whenever a bus answer is handed over.
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      e_cur = q.pop_front();
      chk(rdata & e_cur.m, e_cur.d);
      chk(32'(rresp), 32'(e_cur.r));
    end else if (bvalid === 1'b1 && bready) begin
      e_cur = q.pop_front();
      chk(32'(bresp), 32'(e_cur.r));
    end
  end

  // Cuts a hang short.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      test_done();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    q.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    @(posedge aclk);
    q.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic ticks(input int n, input logic [7:0] e);
    int k;
    k = 0;
    @(posedge aclk);
    perr <= e;
    run <= 1'b1;
    while (k < n) begin
      @(posedge aclk);
      if (pd_tick === 1'b1) k++;
    end
    run <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // Main sequence: reset, lock filter, interrupts, power down, fast acquisition.
  initial begin
    logic [1:0] g;
    int t;
    int m;
    void'($urandom(32'hB9EB462D));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'({lock_detect, irq, ac}), 32'h0);
    rd(`OFS_CTRL, `CTRL_RESET, 32'hFFFFFFFF, 2'h0);
    rd(`OFS_TIMEOUT, 32'(`TIMEOUT_RESET), 32'h3FFF, 2'h0);
    rd(12'h018, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(12'h018, 32'h1, 2'h2);
    ticks(4, 8'h0E);
    chk(32'(lock_detect), 32'h0);
    ticks(1, 8'h0F);
    ticks(4, 8'h0E);
    chk(32'(lock_detect), 32'h0);
    ticks(1, 8'h0E);
    chk(32'(lock_detect), 32'h1);
    rd(`OFS_IRQ_STAT, 32'h1, 32'h3, 2'h0);
    chk(32'(irq), 32'h0);
    wr(`OFS_IRQ_MASK, 32'h3, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    ticks(3, 8'h1E);
    chk(32'(lock_detect), 32'h1);
    ticks(1, 8'h1F);
    chk(32'(lock_detect), 32'h0);
    rd(`OFS_IRQ_STAT, 32'h2, 32'h3, 2'h0);
    wr(`OFS_IRQ_STAT, 32'h2, 2'h0);
    ticks(5, 8'h00);
    wr(`OFS_CTRL, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(lock_detect), 32'h0);
    ticks(5, 8'h00);
    chk(32'(lock_detect), 32'h0);
    wr(`OFS_CTRL, 32'h0, 2'h0);
    ticks(4, 8'h00);
    chk(32'(lock_detect), 32'h0);
    // Fractional then integer mode, with a legal gain pair and a random timeout.
    for (m = 1; m >= 0; m--) begin
      g = 2'($urandom_range(2));
      t = 4 + $urandom_range(3);
      wr(`OFS_CTRL, {22'h0, 2'h1, 2'h3, g, 1'b0, m[0], m[0], 1'b0}, 2'h0);
      wr(`OFS_TIMEOUT, 32'(t), 2'h0);
      wr(`OFS_FREQ, 32'h1, 2'h0);
      repeat (2) @(posedge aclk);
      chk(32'(ac), 32'({2'h3, m[0] ? 2'h1 : 2'h0, m[0], 1'b1}));
      ticks(t - 1, 8'h14);
      chk(32'(ac.fast_engaged), 32'h1);
      ticks(1, 8'h14);
      chk(32'(ac), 32'({g, 2'h0, m[0], 1'b0}));
      rd(`OFS_STATUS, 32'h0, 32'h2, 2'h0);
    end
    wr(`OFS_TIMEOUT, 32'h3, 2'h0);
    wr(`OFS_FREQ, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(ac), 32'({g, 4'h0}));
    wr(`OFS_TIMEOUT, 32'(`TOC_MANUAL), 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(ac.pump_gain), 32'h3);
    test_done();
  end
endmodule
